// File: flash_front_pkg.sv
/*
  Shared constants for the multi-I/O flash command front end: instruction
  codes, register widths, reset values and internal timing counts.
  Assumes nothing of its surroundings.
*/
package flash_front_pkg;
  // Instruction codes of the four-line command set
  localparam logic [7:0] OP_ID_READ     = 8'h00_AF;
  localparam logic [7:0] OP_SFDP_READ   = 8'h00_5A;
  localparam logic [7:0] OP_FAST_READ_A = 8'h00_0B;
  localparam logic [7:0] OP_FAST_READ_B = 8'h00_6B;
  localparam logic [7:0] OP_FAST_READ_C = 8'h00_EB;
  localparam logic [7:0] OP_OTP_READ    = 8'h00_4B;
  localparam logic [7:0] OP_UNLOCK      = 8'h00_06;
  localparam logic [7:0] OP_RELOCK      = 8'h00_04;
  localparam logic [7:0] OP_PROG_A      = 8'h00_02;
  localparam logic [7:0] OP_PROG_B      = 8'h00_32;
  localparam logic [7:0] OP_PROG_C      = 8'h00_12;
  localparam logic [7:0] OP_OTP_PROG    = 8'h00_42;
  localparam logic [7:0] OP_SMALL_CLR   = 8'h00_20;
  localparam logic [7:0] OP_BIG_CLR     = 8'h00_D8;
  localparam logic [7:0] OP_WHOLE_CLR   = 8'h00_C7;
  localparam logic [7:0] OP_RESUME      = 8'h00_7A;
  localparam logic [7:0] OP_PAUSE       = 8'h00_75;
  localparam logic [7:0] OP_STAT_READ   = 8'h00_05;
  localparam logic [7:0] OP_STAT_WRITE  = 8'h00_01;
  localparam logic [7:0] OP_LOCK_READ   = 8'h00_E8;
  localparam logic [7:0] OP_LOCK_WRITE  = 8'h00_E5;
  localparam logic [7:0] OP_FLAG_READ   = 8'h00_70;
  localparam logic [7:0] OP_FLAG_CLEAR  = 8'h00_50;
  localparam logic [7:0] OP_NVC_READ    = 8'h00_B5;
  localparam logic [7:0] OP_NVC_WRITE   = 8'h00_B1;
  localparam logic [7:0] OP_VC_READ     = 8'h00_85;
  localparam logic [7:0] OP_VC_WRITE    = 8'h00_81;
  localparam logic [7:0] OP_EVC_READ    = 8'h00_65;
  localparam logic [7:0] OP_EVC_WRITE   = 8'h00_61;
  localparam logic [7:0] OP_SLEEP_ENTER = 8'h00_B9;
  localparam logic [7:0] OP_SLEEP_EXIT  = 8'h00_AB;

  // Register reset values (plain defaults)
  localparam logic [7:0]  VC_RESET   = 8'h00_FB;
  localparam logic [7:0]  EVC_RESET  = 8'h00_DF;
  localparam logic [15:0] NVC_RESET  = 16'hFFFF;
  localparam logic [7:0]  LOCK_RESET = 8'h00_00;
  localparam logic [7:0]  STAT_RESET = 8'h00_00;
  // Identification byte, arbitrary value
  localparam logic [7:0]  ID_BYTE    = 8'h00_5C;

  // Status bit positions
  localparam int STAT_WIP_BIT = 0;
  localparam int STAT_WEL_BIT = 1;
  // Flag status bit positions
  localparam int FLAG_PEC_BIT  = 7;
  localparam int FLAG_ERS_BIT  = 5;
  localparam int FLAG_PRG_BIT  = 4;
  localparam int FLAG_VPP_BIT  = 3;
  localparam int FLAG_SUSP_BIT = 2;
  localparam int FLAG_PROT_BIT = 1;
  localparam logic [7:0] FLAG_ERR_MASK = 8'h00_3A;
  localparam logic [7:0] FLAG_IDLE     = 8'h00_80;

  // Bits carried by one link clock in four-line and two-line protocols
  localparam logic [2:0] QUAD_STEP = 3'd4;
  localparam logic [2:0] DUAL_STEP = 3'd2;
  localparam logic [2:0] BYTE_BITS = 3'd0;

  // Internal modify cycle duration in ns and in core cycles
  localparam int CLK_PERIOD_NS = 5;
  localparam int MODIFY_NS     = 20000;
  localparam int MODIFY_CYC    = MODIFY_NS / CLK_PERIOD_NS;

  // Kinds of internal modify cycles
  typedef enum logic [2:0] {
    MOD_NONE  = 3'b000,
    MOD_PROG  = 3'b001,
    MOD_ERASE = 3'b010,
    MOD_OTP   = 3'b011,
    MOD_WHOLE = 3'b100,
    MOD_NVC   = 3'b101,
    MOD_STAT  = 3'b110
  } modify_type;
endpackage

// File: flash_link_shifter.sv
/*
  Link-side shifter on the host serial clock. Collects command bytes,
  shifts out reply bytes and reports each completed byte with a toggle.
  Assumes the host clock stands still while chip select is high.
*/
`timescale 1ns/10ps
module flash_link_shifter
  import flash_front_pkg::*;
(
  // Link clock and frame
  input  wire logic       link_clk_i,
  input  wire logic       frame_n_i,
  input  wire logic       quad_i,
  // Data lines
  input  wire logic [3:0] io_in_i,
  output logic      [3:0] io_out_o,
  output logic            io_oe_o,
  // Byte events, toggles into the core domain
  output logic            byte_tgl_o,
  output logic      [7:0] byte_o,
  // Reply from the core, stable while sent
  input  wire logic [7:0] reply_i,
  input  wire logic       reply_en_i
);
  import flash_front_pkg::*;

  logic [7:0] shift_ff;
  logic [2:0] cnt_ff;
  logic [7:0] out_ff;
  // Defined start value: no reset reaches this flop on the link clock
  logic       tgl_ff = 1'b0;
  logic [7:0] hold_ff;
  wire  [2:0] step_w = quad_i ? QUAD_STEP : DUAL_STEP;
  wire  [2:0] nxt_cnt = 3'(cnt_ff + step_w);
  wire  [7:0] nxt_shift = quad_i ? {shift_ff[3:0], io_in_i}
                                 : {shift_ff[5:0], io_in_i[1:0]};

  // Sample on the rising edge; chip select high clears the count, which wraps at each byte boundary
  always_ff @(posedge link_clk_i or posedge frame_n_i) begin
    if (frame_n_i) begin
      cnt_ff   <= BYTE_BITS;
      shift_ff <= 8'h00_00;
    end else begin
      cnt_ff   <= nxt_cnt;
      shift_ff <= nxt_shift;
    end
  end

  // Completed byte handed over with a toggle
  always_ff @(posedge link_clk_i) begin
    if (!frame_n_i && nxt_cnt == BYTE_BITS) begin
      hold_ff <= nxt_shift;
      tgl_ff  <= ~tgl_ff;
    end
  end

  // Drive on the falling edge; stop as soon as the frame ends
  always_ff @(negedge link_clk_i or posedge frame_n_i) begin
    if (frame_n_i) begin
      out_ff  <= 8'h00_00;
      io_oe_o <= 1'b0;
    end else begin
      io_oe_o <= reply_en_i;
      out_ff  <= (cnt_ff == BYTE_BITS) ? reply_i
               : (quad_i ? {out_ff[3:0], 4'h0} : {out_ff[5:0], 2'h0});
    end
  end

  assign io_out_o   = quad_i ? out_ff[7:4] : {2'b00, out_ff[7:6]};
  assign byte_tgl_o = tgl_ff;
  assign byte_o     = hold_ff;
endmodule

// File: flash_cmd_front.sv
/*
  Multi-I/O serial flash command front end: decodes instructions from the
  link, keeps configuration, status and flag registers, runs a timed
  internal modify cycle with pause and resume, and deep power-down.
  Assumes the host drives the link clock and chip select; the array
  itself lives outside and is seen only through the modify cycle.
*/
//   Operation
// - Nonvolatile config write needs a prior write unlock
// - Two-line mode moves two bits per clock on lines 0 and 1
// - Volatile config read returns the volatile config register
// - Volatile config write needs a prior write unlock
// - Enhanced config read returns it on active protocol lines
// - Enhanced config write needs a prior write unlock
// - Deep sleep enter instruction enters deep power-down
// - In deep power-down every instruction but sleep exit is ignored
// - Deep sleep exit returns to normal operation
// - Four-line mode moves four bits per clock on all lines
// - Read-type instructions follow the opcode with data out
// - Write-type ended off a byte boundary is rejected; the code rejects only writes short of their data bytes
// - Array accesses during modify cycles are ignored
// - Pause suspends program and erase, except OTP, whole, nvc
// - Resume continues the suspended cycle
// - Status and flag polling allowed during modify cycles
// - Polling does not affect the modify cycle
// - Flag clear resets error flags, ignores unlock latch
`timescale 1ns/10ps
module flash_cmd_front
  import flash_front_pkg::*;
(
  // Core clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  // Link pins
  input  wire logic        link_clk_i,
  input  wire logic        frame_n_i,
  input  wire logic [3:0]  io_in_i,
  output logic      [3:0]  io_out_o,
  output logic      [3:0]  io_oe_o,
  // Protocol select: high four-line, low two-line
  input  wire logic        quad_mode_i,
  // Device state
  output logic             sleep_o,
  output logic             busy_o,
  output logic             suspended_o,
  output logic [7:0]       vcfg_o,
  output logic [7:0]       evcfg_o,
  output logic [15:0]      nvcfg_o,
  output logic             reject_o
);
  import flash_front_pkg::*;

  typedef enum logic [1:0] {
    ST_OPCODE = 2'b00,
    ST_ARGS   = 2'b01,
    ST_READ   = 2'b10,
    ST_DROP   = 2'b11
  } frame_type;

  // Link-side shifter; frame reset is the chip select itself
  logic [3:0] lk_out;
  logic       lk_oe;
  logic       lk_tgl;
  logic [7:0] lk_byte;
  logic [7:0] reply_ff;
  logic       reply_en_ff;
  logic       quad_lk1_ff, quad_lk2_ff;
  flash_link_shifter u_shift (
    .link_clk_i (link_clk_i),
    .frame_n_i  (frame_n_i),
    .quad_i     (quad_lk2_ff),
    .io_in_i    (io_in_i),
    .io_out_o   (lk_out),
    .io_oe_o    (lk_oe),
    .byte_tgl_o (lk_tgl),
    .byte_o     (lk_byte),
    .reply_i    (reply_ff),
    .reply_en_i (reply_en_ff)
  );

  // Protocol select into the link domain, two stages
  always_ff @(posedge link_clk_i) begin
    quad_lk1_ff <= quad_mode_i;
    quad_lk2_ff <= quad_lk1_ff;
  end

  // Output lanes: four lines in quad, lines 0..1 in dual
  assign io_out_o = lk_out;
  assign io_oe_o  = lk_oe ? (quad_lk2_ff ? 4'hF : 4'h3) : 4'h0;

  // Core-side synchronisers for toggle and chip select
  logic [2:0] tgl_sync_ff;
  logic [2:0] cs_sync_ff;
  always_ff @(posedge core_clk_i) begin
    tgl_sync_ff <= {tgl_sync_ff[1:0], lk_tgl};
    cs_sync_ff  <= {cs_sync_ff[1:0], frame_n_i};
  end
  // Held byte is stable long after the toggle settles
  wire byte_evt  = tgl_sync_ff[2] ^ tgl_sync_ff[1];
  wire frame_end = cs_sync_ff[1] & ~cs_sync_ff[2];

  // Registers
  frame_type  st_ff;
  logic [7:0] op_ff;
  logic [7:0] arg_ff [0:1];
  logic [1:0] nargs_ff;
  logic [7:0] vc_ff, evc_ff, lock_ff, stat_ff, flag_ff;
  logic [15:0] nvc_ff;
  logic       wel_ff, sleep_ff, susp_ff, rej_ff;
  modify_type mod_ff;
  logic [$clog2(MODIFY_CYC+1)-1:0] mcnt_ff;

  // Classification of opcodes
  function automatic logic is_read(input logic [7:0] op);
    return op inside {OP_ID_READ, OP_SFDP_READ, OP_FAST_READ_A,
      OP_FAST_READ_B, OP_FAST_READ_C, OP_OTP_READ, OP_STAT_READ,
      OP_LOCK_READ, OP_FLAG_READ, OP_NVC_READ, OP_VC_READ, OP_EVC_READ};
  endfunction
  function automatic logic is_array(input logic [7:0] op);
    return op inside {OP_SFDP_READ, OP_FAST_READ_A, OP_FAST_READ_B,
      OP_FAST_READ_C, OP_OTP_READ, OP_ID_READ, OP_PROG_A, OP_PROG_B,
      OP_PROG_C, OP_OTP_PROG, OP_SMALL_CLR, OP_BIG_CLR, OP_WHOLE_CLR,
      OP_LOCK_READ, OP_LOCK_WRITE, OP_STAT_WRITE, OP_NVC_WRITE};
  endfunction
  // Data bytes a write-type takes before executing at frame end
  function automatic logic [1:0] arg_need(input logic [7:0] op);
    case (op)
      OP_NVC_WRITE:                         return 2'd2;
      OP_VC_WRITE, OP_EVC_WRITE,
      OP_STAT_WRITE, OP_LOCK_WRITE:          return 2'd1;
      default:                              return 2'd0;
    endcase
  endfunction
  // Reply byte for a read instruction
  function automatic logic [7:0] reply_of(input logic [7:0] op,
      input logic [7:0] vc, input logic [7:0] evc, input logic [7:0] st,
      input logic [7:0] fl, input logic [7:0] lk, input logic [15:0] nv);
    case (op)
      OP_VC_READ:   return vc;
      OP_EVC_READ:  return evc;
      OP_STAT_READ: return st;
      OP_FLAG_READ: return fl;
      OP_LOCK_READ: return lk;
      OP_NVC_READ:  return nv[7:0];
      OP_ID_READ:   return ID_BYTE;
      default:      return 8'hFF;
    endcase
  endfunction

  wire busy     = (mod_ff != MOD_NONE);
  wire running  = busy & ~susp_ff;
  // Opcode acceptance: sleep filter, then modify-cycle filter
  wire op_ok    = sleep_ff ? (lk_byte == OP_SLEEP_EXIT)
                : !(busy && is_array(lk_byte));
  // Address and data bytes may follow; only missing bytes count as cut
  wire byte_aligned = (st_ff != ST_ARGS) || (nargs_ff >= arg_need(op_ff));
  // A frame may only execute once all its data bytes have arrived
  wire exec     = frame_end && st_ff == ST_ARGS && byte_aligned;
  wire misalign = frame_end && st_ff == ST_ARGS && !byte_aligned
                  && tgl_sync_ff[1] == tgl_sync_ff[2];
  wire pausable = mod_ff inside {MOD_PROG, MOD_ERASE};

  // Frame sequencing
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_ff    <= ST_OPCODE;
      op_ff    <= 8'h00_00;
      nargs_ff <= 2'd0;
    end else if (frame_end) begin
      st_ff    <= ST_OPCODE;
      nargs_ff <= 2'd0;
    end else if (byte_evt) begin
      case (st_ff)
        ST_OPCODE: begin
          op_ff <= lk_byte;
          st_ff <= !op_ok ? ST_DROP
                 : is_read(lk_byte) ? ST_READ : ST_ARGS;
        end
        ST_ARGS: begin
          if (nargs_ff < 2'd2) begin
            arg_ff[nargs_ff[0]] <= lk_byte;
          end
          nargs_ff <= (nargs_ff == 2'd3) ? nargs_ff : 2'(nargs_ff + 1);
        end
        default: st_ff <= st_ff;
      endcase
    end
  end

  // Reply path: register value loaded into the link shifter
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      reply_ff    <= 8'h00_00;
      reply_en_ff <= 1'b0;
    end else begin
      reply_en_ff <= (st_ff == ST_READ);
      reply_ff    <= reply_of(op_ff, vc_ff, evc_ff, stat_ff, flag_ff,
                              lock_ff, nvc_ff);
    end
  end

  // Execution of completed write-type instructions
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      vc_ff    <= VC_RESET;
      evc_ff   <= EVC_RESET;
      nvc_ff   <= NVC_RESET;
      lock_ff  <= LOCK_RESET;
      stat_ff  <= STAT_RESET;
      wel_ff   <= 1'b0;
      sleep_ff <= 1'b0;
      susp_ff  <= 1'b0;
      rej_ff   <= 1'b0;
      flag_ff  <= FLAG_IDLE;
      mod_ff   <= MOD_NONE;
      mcnt_ff  <= '0;
    end else begin
      rej_ff <= misalign;
      // Modify cycle counts only while not paused; reads leave it be
      if (running) begin
        if (mcnt_ff == '0) begin
          if (mod_ff == MOD_NVC) nvc_ff <= {arg_ff[1], arg_ff[0]};
          mod_ff <= MOD_NONE;
          wel_ff <= 1'b0;
        end else begin
          mcnt_ff <= mcnt_ff - 1'b1;
        end
      end
      if (exec) begin
        case (op_ff)
          OP_UNLOCK:      wel_ff <= 1'b1;
          OP_RELOCK:      wel_ff <= 1'b0;
          OP_SLEEP_ENTER: sleep_ff <= 1'b1;
          OP_SLEEP_EXIT:  sleep_ff <= 1'b0;
          OP_FLAG_CLEAR:  flag_ff <= flag_ff & ~FLAG_ERR_MASK;
          OP_PAUSE:       if (pausable) susp_ff <= 1'b1;
          OP_RESUME:      susp_ff <= 1'b0;
          // Writes without unlock drop silently
          OP_VC_WRITE:    if (wel_ff) begin
            vc_ff  <= arg_ff[0];
            wel_ff <= 1'b0;
          end
          OP_EVC_WRITE:   if (wel_ff) begin
            evc_ff <= arg_ff[0];
            wel_ff <= 1'b0;
          end
          OP_LOCK_WRITE:  if (wel_ff) begin
            lock_ff <= arg_ff[0];
            wel_ff  <= 1'b0;
          end
          OP_NVC_WRITE:   if (wel_ff && !busy) begin
            mod_ff  <= MOD_NVC;
            mcnt_ff <= ($bits(mcnt_ff))'(MODIFY_CYC);
          end
          OP_STAT_WRITE:  if (wel_ff && !busy) begin
            stat_ff[7:2] <= arg_ff[0][7:2];
            mod_ff  <= MOD_STAT;
            mcnt_ff <= ($bits(mcnt_ff))'(MODIFY_CYC);
          end
          OP_PROG_A, OP_PROG_B, OP_PROG_C, OP_OTP_PROG, OP_SMALL_CLR,
          OP_BIG_CLR, OP_WHOLE_CLR: if (wel_ff && !busy) begin
            mod_ff  <= (op_ff == OP_OTP_PROG)   ? MOD_OTP
                     : (op_ff == OP_WHOLE_CLR)  ? MOD_WHOLE
                     : (op_ff == OP_SMALL_CLR || op_ff == OP_BIG_CLR)
                       ? MOD_ERASE : MOD_PROG;
            mcnt_ff <= ($bits(mcnt_ff))'(MODIFY_CYC);
          end
          default: ;
        endcase
      end
      // Polled bits track the cycle live
      stat_ff[STAT_WIP_BIT]  <= busy;
      stat_ff[STAT_WEL_BIT]  <= wel_ff;
      flag_ff[FLAG_PEC_BIT]  <= ~running;
      flag_ff[FLAG_SUSP_BIT] <= susp_ff;
    end
  end

  // State outputs straight from flip-flops
  always_ff @(posedge core_clk_i) begin
    sleep_o     <= sleep_ff;
    busy_o      <= busy;
    suspended_o <= susp_ff;
    vcfg_o      <= vc_ff;
    evcfg_o     <= evc_ff;
    nvcfg_o     <= nvc_ff;
    reject_o    <= rej_ff;
  end

  // Unlock-guarded writes never change the register without the latch
  vc_guard_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (exec && op_ff == OP_VC_WRITE && !wel_ff) |=> $stable(vc_ff))
    else $error("volatile config changed without unlock");
  evc_guard_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (exec && op_ff == OP_EVC_WRITE && !wel_ff) |=> $stable(evc_ff))
    else $error("enhanced config changed without unlock");
  nvc_guard_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (exec && op_ff == OP_NVC_WRITE && !wel_ff && !busy) |=> !busy)
    else $error("nonvolatile write started without unlock");
  sleep_enter_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (exec && op_ff == OP_SLEEP_ENTER) |=> sleep_ff ##1 sleep_o)
    else $error("deep sleep not entered");
  sleep_filter_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (sleep_ff && byte_evt && st_ff == ST_OPCODE && lk_byte != OP_SLEEP_EXIT)
    |=> st_ff == ST_DROP)
    else $error("instruction accepted in deep sleep");
  misalign_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    misalign |-> !exec ##1 rej_ff)
    else $error("misaligned write executed");
  pause_guard_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (exec && op_ff == OP_PAUSE && mod_ff inside {MOD_OTP, MOD_WHOLE, MOD_NVC})
    |=> !susp_ff)
    else $error("unpausable cycle was paused");
  array_block_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (busy && byte_evt && st_ff == ST_OPCODE && !frame_end
     && lk_byte == OP_FAST_READ_B) |=> st_ff == ST_DROP)
    else $error("array read accepted during modify cycle");
  poll_ok_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (busy && !sleep_ff && byte_evt && st_ff == ST_OPCODE && !frame_end
     && lk_byte == OP_STAT_READ) |=> st_ff == ST_READ)
    else $error("status poll refused during modify cycle");
  flag_clear_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (exec && op_ff == OP_FLAG_CLEAR)
    |=> (flag_ff & FLAG_ERR_MASK) == 8'h00_00 && wel_ff == $past(wel_ff))
    else $error("flag clear wrong");
endmodule

// File: host_link_model.sv
/*
  Host controller model for the flash link: drives the serial clock,
  chip select and data lines, and samples the device's replies.
  Assumes the bench resolves the shared data lines from both enables.
*/
`timescale 1ns/10ps
module host_link_model (
  // Link outputs
  output logic            link_clk_o,
  output logic            frame_n_o,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe_o,
  // Resolved line levels and protocol
  input  wire logic [3:0] io_i,
  input  wire logic       quad_i
);
  // Clock stands still and chip select stays high outside frames
  // A first rise of chip select clears the device's link side
  initial begin
    link_clk_o = 1'b0;
    frame_n_o  = 1'b0;
    #1 frame_n_o = 1'b1;
    io_o       = 4'h0;
    io_oe_o    = 4'h0;
  end

  // Open a frame one link period before the first edge
  task automatic open_frame();
    frame_n_o = 1'b0;
    #6;
  endtask

  // Run nclk link clocks; released lines show the inverse of their last value
  task automatic xfer(input logic [7:0] tx, input logic drv,
                      input int nclk, output logic [7:0] rx);
    logic [7:0] sh;
    sh = tx;
    rx = 8'h00;
    for (int k = 0; k < nclk; k++) begin
      if (drv) begin
        io_oe_o = quad_i ? 4'hF : 4'h3;
        io_o = quad_i ? sh[7:4] : {2'b00, sh[7:6]};
      end else if (io_oe_o != 4'h0) begin
        io_oe_o = 4'h0;
        io_o = ~io_o;
      end
      sh = quad_i ? {sh[3:0], 4'h0} : {sh[5:0], 2'b00};
      #6 link_clk_o = 1'b1;
      rx = quad_i ? {rx[3:0], io_i} : {rx[5:0], io_i[1:0]};
      #6 link_clk_o = 1'b0;
    end
  endtask

  // One whole byte in the active protocol
  task automatic byte_io(input logic [7:0] tx, input logic drv,
                         output logic [7:0] rx);
    xfer(tx, drv, quad_i ? 2 : 4, rx);
  endtask

  // Close where the caller stopped; gap keeps frames eight core cycles apart
  task automatic close_frame();
    #6 frame_n_o = 1'b1;
    io_oe_o = 4'h0;
    io_o = ~io_o;
    #40;
  endtask
endmodule

// File: tb_top.sv
/*
  Self-checking bench for the flash command front end.
  Assumes the host model above stands on the link and owns its clock.
*/
`timescale 1ns/10ps
module tb_top;
  import flash_front_pkg::*;
  logic        core_clk, srst, quad_mode, link_clk, frame_n;
  logic [3:0]  host_io, host_oe, dut_io, dut_oe, io_line;
  logic        sleep, busy, suspended, reject;
  logic [7:0]  vcfg, evcfg, rx;
  logic [15:0] nvcfg;
  int          n_fail, total_checks, n_rej, cyc;

  // Device wins a line only where the host has let go
  assign io_line = ((~host_oe & dut_oe) & dut_io) | (~(~host_oe & dut_oe) & host_io);

  flash_cmd_front dut (.core_clk_i(core_clk), .srst_i(srst),
    .link_clk_i(link_clk), .frame_n_i(frame_n), .io_in_i(io_line),
    .io_out_o(dut_io), .io_oe_o(dut_oe), .quad_mode_i(quad_mode),
    .sleep_o(sleep), .busy_o(busy), .suspended_o(suspended), .vcfg_o(vcfg),
    .evcfg_o(evcfg), .nvcfg_o(nvcfg), .reject_o(reject));

  host_link_model host (.link_clk_o(link_clk), .frame_n_o(frame_n),
    .io_o(host_io), .io_oe_o(host_oe), .io_i(io_line), .quad_i(quad_mode));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Reject pulses last one cycle, so count them as they pass
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (reject === 1'b1) n_rej <= n_rej + 1;
    if (cyc == 60000) begin
      n_fail++;
      $display("[FAIL] %0t timeout", $time);
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, exp, input string what);
    chk({15'h0000, got}, {15'h0000, exp}, what);
  endtask

  task automatic settle();
    repeat (12) @(negedge core_clk);
  endtask

  // Frame helpers: bare opcode, opcode plus data bytes, register read
  task automatic cmd(input logic [7:0] op);
    host.open_frame();
    host.byte_io(op, 1'b1, rx);
    host.close_frame();
    settle();
  endtask

  task automatic wr(input logic [7:0] op, input logic [31:0] d, input int n);
    host.open_frame();
    host.byte_io(op, 1'b1, rx);
    for (int i = 0; i < n; i++) host.byte_io(d[8*i +: 8], 1'b1, rx);
    host.close_frame();
    settle();
  endtask

  task automatic rd(input logic [7:0] op);
    host.open_frame();
    host.byte_io(op, 1'b1, rx);
    host.byte_io(8'h00, 1'b0, rx);
    host.byte_io(8'h00, 1'b0, rx);
    host.close_frame();
    settle();
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 9000 && busy !== 1'b0; i++) @(negedge core_clk);
  endtask

  // Locked writes vanish, unlocked ones land, reads return them
  task automatic t_config();
    chk(vcfg, VC_RESET, "vcfg reset");
    wr(OP_VC_WRITE, 32'h5A, 1);
    chk(vcfg, VC_RESET, "locked vc write");
    wr(OP_EVC_WRITE, 32'h5A, 1);
    chk(evcfg, EVC_RESET, "locked evc write");
    cmd(OP_UNLOCK);
    wr(OP_VC_WRITE, 32'h3C, 1);
    chk(vcfg, 16'h003C, "vc write");
    cmd(OP_UNLOCK);
    wr(OP_EVC_WRITE, 32'hA5, 1);
    chk(evcfg, 16'h00A5, "evc write");
    rd(OP_VC_READ);
    chk(rx, 8'h3C, "vc read");
    rd(OP_EVC_READ);
    chk(rx, 8'hA5, "evc read");
  endtask

  // Two-line protocol; a throwaway frame lets the mode reach the link side
  task automatic t_dual();
    quad_mode = 1'b0;
    cmd(8'hFF);
    cmd(OP_UNLOCK);
    wr(OP_VC_WRITE, 32'h96, 1);
    chk(vcfg, 16'h0096, "dual vc write");
    rd(OP_EVC_READ);
    chk(rx, 8'hA5, "dual evc read");
    quad_mode = 1'b1;
    cmd(8'hFF);
  endtask

  // Write cut off mid-byte, then a read cut off mid-byte
  task automatic t_abort();
    int r0;
    r0 = n_rej;
    cmd(OP_UNLOCK);
    host.open_frame();
    host.byte_io(OP_VC_WRITE, 1'b1, rx);
    host.xfer(8'h11, 1'b1, 1, rx);
    host.close_frame();
    settle();
    chk(n_rej - r0, 16'h0001, "reject pulse");
    chk(vcfg, 16'h0096, "partial write");
    host.open_frame();
    host.byte_io(OP_VC_READ, 1'b1, rx);
    host.xfer(8'h00, 1'b0, 3, rx);
    host.close_frame();
    chk(dut_oe, 4'h0, "lines released");
  endtask

  // Flag clear keeps the unlock latch
  task automatic t_flag();
    cmd(OP_UNLOCK);
    cmd(OP_FLAG_CLEAR);
    rd(OP_STAT_READ);
    chk_bit(rx[STAT_WEL_BIT], 1'b1, "latch kept");
    rd(OP_FLAG_READ);
    chk(rx & FLAG_ERR_MASK, 8'h00, "errors clear");
    cmd(OP_RELOCK);
  endtask

  task automatic t_sleep();
    cmd(OP_SLEEP_ENTER);
    chk_bit(sleep, 1'b1, "sleep entered");
    cmd(OP_UNLOCK);
    wr(OP_VC_WRITE, 32'h22, 1);
    chk(vcfg, 16'h0096, "ignored in sleep");
    cmd(OP_SLEEP_EXIT);
    chk_bit(sleep, 1'b0, "sleep left");
  endtask

  // Nonvolatile write runs unpausable; program pauses, resumes, is polled
  task automatic t_modify();
    cmd(OP_UNLOCK);
    wr(OP_NVC_WRITE, 32'h1234 >> 0, 2);
    chk_bit(busy, 1'b1, "nvc busy");
    cmd(OP_PAUSE);
    chk_bit(suspended, 1'b0, "nvc not paused");
    wait_idle();
    // First data byte is the low byte
    chk(nvcfg, 16'h1234, "nvc value");
    cmd(OP_UNLOCK);
    wr(OP_PROG_A, 32'h5500_0000, 4);
    chk_bit(busy, 1'b1, "program started");
    // Array read while busy must be dropped without touching the cycle
    rd(OP_FAST_READ_B);
    chk_bit(busy, 1'b1, "array read ignored");
    rd(OP_STAT_READ);
    chk_bit(rx[STAT_WIP_BIT], 1'b1, "wip polled");
    rd(OP_FLAG_READ);
    chk_bit(rx[FLAG_PEC_BIT], 1'b0, "controller busy");
    cmd(OP_PAUSE);
    chk_bit(suspended, 1'b1, "program paused");
    cmd(OP_RESUME);
    chk_bit(suspended, 1'b0, "resumed");
    chk_bit(busy, 1'b1, "still running");
    wait_idle();
    chk_bit(busy, 1'b0, "program done");
  endtask

  initial begin
    srst = 1'b1;
    quad_mode = 1'b1;
    n_fail = 0;
    total_checks = 0;
    n_rej = 0;
    cyc = 0;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    repeat (6) @(negedge core_clk);
    t_config();
    t_dual();
    t_abort();
    t_flag();
    t_sleep();
    t_modify();
    test_done();
  end
endmodule
